//--- rtl/lp_baud_gen.sv
`timescale 1ns/1ns
module lp_baud_gen
   import uart_lp_divisor_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [DIV_W-1:0] divisor,
   output logic tick_r,
   output logic running_r
);

   logic [DIV_W-1:0] count_r;

   generate
      if (DIV_W < 2) begin : g_bad_width
         $error("lp_baud_gen: DIV_W must be at least 2");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (reset) begin
         count_r <= '0;
         tick_r <= 1'b0;
      end else if (divisor == '0) begin
         count_r <= '0;
         tick_r <= 1'b0;
      end else if (count_r == '0) begin
         count_r <= divisor - {{(DIV_W-1){1'b0}}, 1'b1};
         tick_r <= 1'b1;
      end else begin
         count_r <= count_r - {{(DIV_W-1){1'b0}}, 1'b1};
         tick_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         running_r <= 1'b0;
      end else begin
         running_r <= (divisor != '0);
      end
   end

endmodule

//--- rtl/uart_lp_divisor.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "uart_lp_divisor_defs.svh"
module uart_lp_divisor
   import uart_lp_divisor_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int MIN_PULSE_TICKS = `SIR_MIN_PULSE_TICKS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sir_in,
   output logic lp_tick_r,
   output logic lp_running_r,
   output logic sir_pulse_r
);

   generate
      if (ADDR_W != 32) begin : g_bad_addr
         $error("uart_lp_divisor: ADDR_W must be 32");
      end
      if (MIN_PULSE_TICKS < 1 || MIN_PULSE_TICKS > 15) begin : g_bad_ticks
         $error("uart_lp_divisor: MIN_PULSE_TICKS must be 1 to 15");
      end
   endgenerate

   localparam logic [3:0] MIN_TICKS = 4'(MIN_PULSE_TICKS);

   byte_reg_t low_power_divisor_low_r;
   byte_reg_t low_power_divisor_high_r;
   byte_reg_t line_control_register_r;
   logic pulse_seen_r;
   lp_divisor_t lp_divisor;
   logic divisor_latch_access;

   logic [ADDR_W-1:0] aw_addr_r;
   logic aw_held_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_held_r;
   logic do_write;
   logic do_read;
   logic status_read;

   sir_state_t sir_state_r;
   logic [3:0] high_ticks_r;
   logic baud_tick;
   logic baud_running;

   assign lp_divisor = {low_power_divisor_high_r, low_power_divisor_low_r};
   assign divisor_latch_access = line_control_register_r[`DIV_ACCESS_BIT];

   // ---------------- write channel ----------------
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (reset) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         w_held_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   // ready only while the holding slot is empty
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         case (aw_addr_r)
            `LINE_CTRL_ADDR,
            `LPDIV_LOW_ADDR,
            `LPDIV_HIGH_ADDR,
            `LPDIV_STATUS_ADDR: s_axi_bresp <= `AXI_RESP_OKAY;
            default: s_axi_bresp <= `AXI_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         line_control_register_r <= `LINE_CTRL_RESET;
      end else if (do_write && aw_addr_r == `LINE_CTRL_ADDR && w_strb_r[0]) begin
         line_control_register_r <= w_data_r[7:0];
      end
   end

   // divisor writes gated by access bit
   always_ff @(posedge clk) begin
      if (reset) begin
         low_power_divisor_low_r <= `LPDIV_BYTE_RESET;
      end else if (do_write && divisor_latch_access && w_strb_r[0]
                   && aw_addr_r == `LPDIV_LOW_ADDR) begin
         low_power_divisor_low_r <= w_data_r[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         low_power_divisor_high_r <= `LPDIV_BYTE_RESET;
      end else if (do_write && divisor_latch_access && w_strb_r[0]
                   && aw_addr_r == `LPDIV_HIGH_ADDR) begin
         low_power_divisor_high_r <= w_data_r[7:0];
      end
   end

   // ---------------- read channel ----------------
   assign do_read = s_axi_arvalid && s_axi_arready;
   assign status_read = do_read && s_axi_araddr == `LPDIV_STATUS_ADDR;

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !do_read;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `AXI_RESP_OKAY;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `AXI_RESP_OKAY;
         s_axi_rdata <= '0;
         case (s_axi_araddr)
            `LINE_CTRL_ADDR: s_axi_rdata[7:0] <= line_control_register_r;
            // divisor reads gated by access bit
            `LPDIV_LOW_ADDR: begin
               if (divisor_latch_access) begin
                  s_axi_rdata[7:0] <= low_power_divisor_low_r;
               end
            end
            `LPDIV_HIGH_ADDR: begin
               if (divisor_latch_access) begin
                  s_axi_rdata[7:0] <= low_power_divisor_high_r;
               end
            end
            `LPDIV_STATUS_ADDR: begin
               s_axi_rdata[`STAT_RUN_BIT] <= baud_running;
               s_axi_rdata[`STAT_PULSE_BIT] <= pulse_seen_r;
               s_axi_rdata[`STAT_SIR_LEVEL_BIT] <= sir_in;
            end
            default: s_axi_rresp <= `AXI_RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- low-power baud clock ----------------
   // divide by divisor: one tick every divisor clocks
   lp_baud_gen #(
      .DIV_W(16)
   ) u_baud (
      .clk(clk),
      .reset(reset),
      .divisor(lp_divisor),
      .tick_r(baud_tick),
      .running_r(baud_running)
   );

   assign lp_tick_r = baud_tick;
   assign lp_running_r = baud_running;

   // ---------------- minimum-width pulse detector ----------------
   // pulse width measured in low-power ticks
   always_ff @(posedge clk) begin
      if (reset) begin
         sir_state_r <= sir_idle;
         high_ticks_r <= '0;
         sir_pulse_r <= 1'b0;
      end else if (lp_divisor == '0) begin
         sir_state_r <= sir_idle;
         high_ticks_r <= '0;
         sir_pulse_r <= 1'b0;
      end else begin
         sir_pulse_r <= 1'b0;
         if (baud_tick) begin
            case (sir_state_r)
               sir_idle: begin
                  if (sir_in) begin
                     if (MIN_TICKS == 4'd1) begin
                        sir_pulse_r <= 1'b1;
                        sir_state_r <= sir_wait_low;
                     end else begin
                        high_ticks_r <= 4'd1;
                        sir_state_r <= sir_high;
                     end
                  end
               end
               sir_high: begin
                  if (!sir_in) begin
                     sir_state_r <= sir_idle;
                     high_ticks_r <= '0;
                  end else if (high_ticks_r + 4'd1 >= MIN_TICKS) begin
                     sir_pulse_r <= 1'b1;
                     sir_state_r <= sir_wait_low;
                  end else begin
                     high_ticks_r <= high_ticks_r + 4'd1;
                  end
               end
               sir_wait_low: begin
                  if (!sir_in) begin
                     sir_state_r <= sir_idle;
                     high_ticks_r <= '0;
                  end
               end
               default: begin
                  sir_state_r <= sir_idle;
                  high_ticks_r <= '0;
               end
            endcase
         end
      end
   end

   // sticky pulse flag, cleared by a status read; a new pulse wins
   always_ff @(posedge clk) begin
      if (reset) begin
         pulse_seen_r <= 1'b0;
      end else if (sir_pulse_r) begin
         pulse_seen_r <= 1'b1;
      end else if (status_read) begin
         pulse_seen_r <= 1'b0;
      end
   end

endmodule

//--- shared/uart_lp_divisor_defs.svh
`ifndef UART_LP_DIVISOR_DEFS_SVH
`define UART_LP_DIVISOR_DEFS_SVH

// register byte addresses
`define LINE_CTRL_ADDR 32'h5000_100c
`define LPDIV_LOW_ADDR 32'h5000_1020
`define LPDIV_HIGH_ADDR 32'h5000_1024
`define LPDIV_STATUS_ADDR 32'h5000_1028

// field positions
`define DIV_ACCESS_BIT 7
`define STAT_RUN_BIT 0
`define STAT_PULSE_BIT 1
`define STAT_SIR_LEVEL_BIT 2

// reset values
`define LPDIV_BYTE_RESET 8'h00
`define LINE_CTRL_RESET 8'h00

// bus answers
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

// receiver timing: ticks of the 16x low-power clock a pulse must stay high
`define SIR_MIN_PULSE_TICKS 2

`endif

//--- shared/uart_lp_divisor_pkg.sv
package uart_lp_divisor_pkg;

   typedef logic [7:0] byte_reg_t;
   typedef logic [15:0] lp_divisor_t;
   typedef logic [1:0] axi_resp_t;

   typedef enum logic [1:0] {
      sir_idle,
      sir_high,
      sir_wait_low
   } sir_state_t;

endpackage

//--- sim/test_uart_lp_divisor.sv
`timescale 1ns/1ns
`include "uart_lp_divisor_defs.svh"
module test_uart_lp_divisor import uart_lp_divisor_pkg::*; ;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sir_in = 1'b0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic lp_tick_r, lp_running_r, sir_pulse_r;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int n_mismatch = 0, checks = 0, nt, np;
   localparam axi_resp_t ok = `AXI_RESP_OKAY;
   localparam axi_resp_t err = `AXI_RESP_SLVERR;
   localparam logic [31:0] lo = `LPDIV_LOW_ADDR, hi = `LPDIV_HIGH_ADDR;
   localparam logic [31:0] line_ctrl = `LINE_CTRL_ADDR, stat = `LPDIV_STATUS_ADDR;
   always #5 clk = ~clk;
   uart_lp_divisor i_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sir_in, .lp_tick_r,
      .lp_running_r, .sir_pulse_r);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input byte_reg_t d, input axi_resp_t er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      // late ready, so the slave must hold its answer
      repeat (2) @(posedge clk);
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input axi_resp_t er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      @(posedge clk);
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
   endtask
   // cycles from one baud tick to the next
   task automatic tick_gap(output int n);
      do @(posedge clk); while (lp_tick_r !== 1'b1);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (lp_tick_r !== 1'b1);
   endtask
   task automatic count_out(input int cyc, output int t, output int p);
      t = 0;
      p = 0;
      repeat (cyc) begin
         @(posedge clk);
         if (lp_tick_r === 1'b1) t++;
         if (sir_pulse_r === 1'b1) p++;
      end
   endtask
   task automatic t_access;
      wr(lo, 8'h5a, ok);
      wr(line_ctrl, 8'h80, ok);
      rd(line_ctrl, 32'h80, ok);
      rd(lo, 32'h0, ok);
      rd(hi, 32'h0, ok);
      wr(lo, 8'ha5, ok);
      wr(hi, 8'h3c, ok);
      // a write with byte lane 0 off must leave the divisor alone
      s_axi_wstrb <= 4'h0;
      wr(lo, 8'h77, ok);
      s_axi_wstrb <= 4'h1;
      rd(lo, 32'ha5, ok);
      rd(hi, 32'h3c, ok);
      wr(line_ctrl, 8'h00, ok);
      rd(hi, 32'h0, ok);
      wr(line_ctrl, 8'h80, ok);
      wr(hi, 8'h00, ok);
      wr(lo, 8'h00, ok);
   endtask
   task automatic t_unmapped;
      wr(32'h5000_1040, 8'h11, err);
      rd(32'h5000_1040, 32'h0, err);
   endtask
   task automatic t_baud;
      // divisor 54 gives the 115.2K low-power rate from the 100 MHz clock
      wr(lo, 8'h36, ok);
      tick_gap(nt);
      chk(nt, 54);
      chk(lp_running_r, 1'b1);
      wr(hi, 8'h01, ok);
      wr(lo, 8'h00, ok);
      tick_gap(nt);
      tick_gap(nt);
      chk(nt, 256);
   endtask
   task automatic t_sir;
      wr(hi, 8'h00, ok);
      wr(lo, 8'h03, ok);
      repeat (8) @(posedge clk);
      repeat (2) begin
         sir_in <= 1'b1;
         count_out(60, nt, np);
         chk(np, 1);
         chk(nt, 20);
         sir_in <= 1'b0;
         count_out(20, nt, np);
      end
      // running, pulse seen, input low; the read clears the pulse flag
      rd(stat, 32'h3, ok);
      rd(stat, 32'h1, ok);
   endtask
   task automatic t_zero;
      wr(lo, 8'h00, ok);
      repeat (4) @(posedge clk);
      chk(lp_running_r, 1'b0);
      sir_in <= 1'b1;
      count_out(100, nt, np);
      chk(nt, 0);
      chk(np, 0);
      sir_in <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("mismatches=%0d checks=%0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_access;
      t_unmapped;
      t_baud;
      t_sir;
      t_zero;
      report_and_stop;
   end
endmodule

//--- sim/uart_lp_divisor_monitor.sv
`timescale 1ns/1ns
module uart_lp_divisor_monitor #(
   parameter int MIN_PULSE_TICKS = 2
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sir_in,
   input wire logic lp_tick_r,
   input wire logic lp_running_r,
   input wire logic sir_pulse_r
);
   logic [3:0] hi_ticks_r;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // consecutive ticks that found the infrared input high, saturating
   always_ff @(posedge clk) begin
      if (reset) begin
         hi_ticks_r <= 4'h0;
      end else if (lp_tick_r) begin
         hi_ticks_r <= !sir_in ? 4'h0 : (hi_ticks_r == 4'hf) ? hi_ticks_r : hi_ticks_r + 4'h1;
      end
   end
   property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_rd_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_rd_byte: assert property (p_rd_byte) else $error("upper read bits set");
   property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
   property p_wr_ans; s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid; endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
   property p_stop_tick; !lp_running_r && !$past(lp_running_r) |-> !lp_tick_r; endproperty
   a_stop_tick: assert property (p_stop_tick) else $error("tick while stopped");
   property p_stop_pulse; !lp_running_r [*3] |-> !sir_pulse_r; endproperty
   a_stop_pulse: assert property (p_stop_pulse) else $error("pulse while stopped");
   property p_pulse_min; sir_pulse_r |-> hi_ticks_r >= MIN_PULSE_TICKS; endproperty
   a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");
   c_tick: cover property (lp_tick_r);
   c_pulse: cover property (sir_pulse_r);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind uart_lp_divisor uart_lp_divisor_monitor #(.MIN_PULSE_TICKS(MIN_PULSE_TICKS)) i_mon (
   .clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sir_in,
   .lp_tick_r, .lp_running_r, .sir_pulse_r);
